//--- pm_pkg.sv
// Package holding constants and carrier types for the port 5/6 pin mux
package pm_pkg;
   // ----------------------------------------
   // Widths and pin positions
   // ----------------------------------------
   localparam int          PM_PORT_W      = 8;   // Pins per port
   localparam int          PM_P5_STE_CLK  = 0;   // Shared strobe / A clock pin
   localparam int          PM_P5_DATA     = 1;   // B master out / I2C data
   localparam int          PM_P5_MISO     = 2;   // B master in / I2C clock
   localparam int          PM_P5_CLK_STE  = 3;   // B clock / A strobe
   localparam int          PM_P5_CLK0     = 4;   // First of three clock outputs
   localparam int          PM_P5_AUX      = 7;   // Timer hi-z in / supervisor out
   localparam int          PM_P6_SVS      = 7;   // Supervisor external input pin
   localparam logic [3:0]  PM_SVS_EXT_LVL = 4'hf; // Level select that uses pin
   localparam logic [7:0]  PM_RST_BYTE    = 8'h00; // Reset value of all bytes

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   // Per-pin output and enable from one serial channel
   typedef struct packed {
      logic out;
      logic oe;
   } pm_sig_s;

   // Pad-facing value set for one port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pm_pad_s;
endpackage

//--- pm_sync.sv
// Two-flop synchroniser for a vector of pin inputs
module pm_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // First stage is read only by the second
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end
endmodule

//--- pm_mux.sv
// Pin function multiplexer for ports 5 and 6
//
// Notes on behaviour
// (RL1) P5.1 select routes B data / I2C data
// (RL2) P5.2 select routes B in / I2C clock
// (RL3) P5.0 select connects B strobe / A clock
// (RL4) P5.3 select connects B clock / A strobe
// (RL5) Serial module sets direction of four pins
// (RL6) I2C pins drive low only, else release
// (RL7) A clock beats B strobe on P5.0
// (RL8) A clock need forces 3-wire SPI
// (RL9) GPIO default; clocks out; analog routing
module pm_mux
   import pm_pkg::*;
(
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RESETN,
   // Software port bits
   input  wire logic [7:0]            PORT5_DIRECTION_BITS,
   input  wire logic [7:0]            PORT5_FUNCTION_SELECT,
   input  wire logic [7:0]            PORT5_OUT_BITS,
   input  wire logic [7:0]            PORT6_DIRECTION_BITS,
   input  wire logic [7:0]            PORT6_FUNCTION_SELECT,
   input  wire logic [7:0]            PORT6_OUT_BITS,
   input  wire logic [7:0]            ANALOG_INPUT_ENABLE,
   // Serial channels
   input  wire logic                  CHAN_B_I2C_MODE,
   input  wire logic                  CHAN_A_CLOCK_NEEDED,
   input  wire pm_pkg::pm_sig_s       CHAN_A_SERIAL_CLOCK,
   input  wire pm_pkg::pm_sig_s       CHAN_B_SLAVE_STROBE,
   input  wire pm_pkg::pm_sig_s       CHAN_B_MASTER_OUT,
   input  wire pm_pkg::pm_sig_s       CHAN_B_MASTER_IN,
   input  wire pm_pkg::pm_sig_s       CHAN_B_SERIAL_CLOCK,
   input  wire pm_pkg::pm_sig_s       CHAN_A_SLAVE_STROBE,
   input  wire logic                  CHAN_A_4WIRE_REQ,
   input  wire logic                  CHAN_B_4WIRE_REQ,
   // Clock system and supervisor
   input  wire logic [2:0]            SYS_CLOCKS,
   input  wire logic                  SUPERVISOR_OUTPUT,
   input  wire logic [3:0]            SUPERVISOR_LEVEL_SELECT,
   // Pads
   input  wire logic [7:0]            P5_PAD_IN,
   input  wire logic [7:0]            P6_PAD_IN,
   output logic      [7:0]            P5_PAD_OUT,
   output logic      [7:0]            P5_PAD_OE,
   output logic      [7:0]            P6_PAD_OUT,
   output logic      [7:0]            P6_PAD_OE,
   // Values back to software and peripherals
   output logic      [7:0]            PORT5_IN_BITS,
   output logic      [7:0]            PORT6_IN_BITS,
   output logic      [7:0]            P5_PERIPH_IN,
   output logic      [7:0]            ANALOG_PIN_ROUTE,
   output logic                       TIMER_OUTPUTS_HIGH_Z,
   output logic                       SUPERVISOR_EXTERNAL_INPUT,
   output logic                       CHAN_A_FORCE_3WIRE,
   output logic                       CHAN_B_FORCE_3WIRE
);
   // ----------------------------------------
   // Synchronised pad inputs
   // ----------------------------------------
   logic [7:0] p5_sync;       // Port 5 pads after two flops
   logic [7:0] p6_sync;       // Port 6 pads after two flops

   pm_sync #(.W(PM_PORT_W)) u_sync5 (
      .clk   (CLK),
      .rst_n (RESETN),
      .d     (P5_PAD_IN),
      .q     (p5_sync)
   );

   pm_sync #(.W(PM_PORT_W)) u_sync6 (
      .clk   (CLK),
      .rst_n (RESETN),
      .d     (P6_PAD_IN),
      .q     (p6_sync)
   );

   // ----------------------------------------
   // Registered output state
   // ----------------------------------------
   pm_pad_s    p5_r,   p5_nxt;     // Port 5 pad drive
   pm_pad_s    p6_r,   p6_nxt;     // Port 6 pad drive
   logic [7:0] in5_r,  in5_nxt;    // Port 5 readback
   logic [7:0] in6_r,  in6_nxt;    // Port 6 readback
   logic [7:0] per_r,  per_nxt;    // Peripheral inputs from port 5
   logic [7:0] ana_r,  ana_nxt;    // Analog routing per port 6 pin
   logic       thz_r,  thz_nxt;    // Timer hi-z request
   logic       svi_r,  svi_nxt;    // Supervisor external input
   logic       fa_r,   fa_nxt;     // Channel A forced to 3-wire
   logic       fb_r,   fb_nxt;     // Channel B forced to 3-wire

   // Pick one serial signal onto a pad, open-drain when i2c is set
   function automatic pm_sig_s pad_drive(input pm_sig_s s, input logic i2c);
      pm_sig_s r;
      r = s;
      if (i2c) begin
         r.out = 1'b0;                  // Only low is ever driven [RL6]
         r.oe  = s.oe & ~s.out;         // Release for high [RL6]
      end
      return r;
   endfunction

   // ----------------------------------------
   // Next-value logic
   // ----------------------------------------
   always_comb begin
      pm_sig_s s;
      s       = '0;
      p5_nxt  = '0;
      p6_nxt  = '0;
      // Plain I/O by default: direction bit picks out (1) or in (0) [RL9]
      p5_nxt.out = PORT5_OUT_BITS;
      p5_nxt.oe  = PORT5_DIRECTION_BITS;
      p6_nxt.out = PORT6_OUT_BITS;
      p6_nxt.oe  = PORT6_DIRECTION_BITS;
      per_nxt    = p5_sync & PORT5_FUNCTION_SELECT;
      // Shared pin P5.0: A clock wins over B strobe [RL7]
      if (PORT5_FUNCTION_SELECT[PM_P5_STE_CLK]) begin
         if (CHAN_A_CLOCK_NEEDED) begin
            s = CHAN_A_SERIAL_CLOCK;                     // [RL3] [RL7]
         end else begin
            s = CHAN_B_SLAVE_STROBE;                     // [RL3]
         end
         p5_nxt.out[PM_P5_STE_CLK] = s.out;              // Direction from serial [RL5]
         p5_nxt.oe[PM_P5_STE_CLK]  = s.oe;
      end
      // P5.1: B data out or I2C data
      if (PORT5_FUNCTION_SELECT[PM_P5_DATA]) begin
         s = pad_drive(CHAN_B_MASTER_OUT, CHAN_B_I2C_MODE); // [RL1] [RL6]
         p5_nxt.out[PM_P5_DATA] = s.out;                 // [RL5]
         p5_nxt.oe[PM_P5_DATA]  = s.oe;
      end
      // P5.2: B data in or I2C clock
      if (PORT5_FUNCTION_SELECT[PM_P5_MISO]) begin
         s = pad_drive(CHAN_B_MASTER_IN, CHAN_B_I2C_MODE);  // [RL2] [RL6]
         p5_nxt.out[PM_P5_MISO] = s.out;                 // [RL5]
         p5_nxt.oe[PM_P5_MISO]  = s.oe;
      end
      // P5.3: B clock or A strobe; a used A clock leaves A without strobe
      if (PORT5_FUNCTION_SELECT[PM_P5_CLK_STE]) begin
         if (CHAN_A_4WIRE_REQ && !CHAN_A_CLOCK_NEEDED) begin
            s = CHAN_A_SLAVE_STROBE;                     // [RL4]
         end else begin
            s = CHAN_B_SERIAL_CLOCK;                     // [RL4]
         end
         p5_nxt.out[PM_P5_CLK_STE] = s.out;              // [RL5]
         p5_nxt.oe[PM_P5_CLK_STE]  = s.oe;
      end
      // P5.4..6: system clocks out when select and direction set [RL9]
      for (int i = 0; i < 3; i++) begin
         if (PORT5_FUNCTION_SELECT[PM_P5_CLK0+i]) begin
            p5_nxt.out[PM_P5_CLK0+i] = SYS_CLOCKS[i];
            p5_nxt.oe[PM_P5_CLK0+i]  = PORT5_DIRECTION_BITS[PM_P5_CLK0+i];
         end
      end
      // P5.7: supervisor out when driven, timer hi-z input otherwise
      thz_nxt = 1'b0;
      if (PORT5_FUNCTION_SELECT[PM_P5_AUX]) begin
         if (PORT5_DIRECTION_BITS[PM_P5_AUX]) begin
            p5_nxt.out[PM_P5_AUX] = SUPERVISOR_OUTPUT;
         end else begin
            thz_nxt = p5_sync[PM_P5_AUX];
         end
      end
      // Pin-needed A clock forces 4-wire channels to 3-wire [RL8]
      fa_nxt = PORT5_FUNCTION_SELECT[PM_P5_STE_CLK] & CHAN_A_CLOCK_NEEDED
               & CHAN_A_4WIRE_REQ;                       // [RL8]
      fb_nxt = PORT5_FUNCTION_SELECT[PM_P5_STE_CLK] & CHAN_A_CLOCK_NEEDED
               & CHAN_B_4WIRE_REQ;                       // [RL8]
      // Port 6: analog enable isolates digital drive [RL9]
      ana_nxt   = ANALOG_INPUT_ENABLE;
      p6_nxt.oe = p6_nxt.oe & ~ANALOG_INPUT_ENABLE;
      // P6.7 select+dir drives ground
      if (PORT6_FUNCTION_SELECT[PM_P6_SVS] && !ANALOG_INPUT_ENABLE[PM_P6_SVS]) begin
         p6_nxt.out[PM_P6_SVS] = 1'b0;
      end
      svi_nxt = ANALOG_INPUT_ENABLE[PM_P6_SVS]
                & (SUPERVISOR_LEVEL_SELECT == PM_SVS_EXT_LVL);
      // Readback; analog pins read low since the buffer is off
      in5_nxt = p5_sync;
      in6_nxt = p6_sync & ~ANALOG_INPUT_ENABLE;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         p5_r  <= '0;
         p6_r  <= '0;
         in5_r <= PM_RST_BYTE;
         in6_r <= PM_RST_BYTE;
         per_r <= PM_RST_BYTE;
         ana_r <= PM_RST_BYTE;
         thz_r <= 1'b0;
         svi_r <= 1'b0;
         fa_r  <= 1'b0;
         fb_r  <= 1'b0;
      end else begin
         p5_r  <= p5_nxt;
         p6_r  <= p6_nxt;
         in5_r <= in5_nxt;
         in6_r <= in6_nxt;
         per_r <= per_nxt;
         ana_r <= ana_nxt;
         thz_r <= thz_nxt;
         svi_r <= svi_nxt;
         fa_r  <= fa_nxt;
         fb_r  <= fb_nxt;
      end
   end

   // Outputs straight from flops
   assign P5_PAD_OUT                = p5_r.out;
   assign P5_PAD_OE                 = p5_r.oe;
   assign P6_PAD_OUT                = p6_r.out;
   assign P6_PAD_OE                 = p6_r.oe;
   assign PORT5_IN_BITS             = in5_r;
   assign PORT6_IN_BITS             = in6_r;
   assign P5_PERIPH_IN              = per_r;
   assign ANALOG_PIN_ROUTE          = ana_r;
   assign TIMER_OUTPUTS_HIGH_Z      = thz_r;
   assign SUPERVISOR_EXTERNAL_INPUT = svi_r;
   assign CHAN_A_FORCE_3WIRE        = fa_r;
   assign CHAN_B_FORCE_3WIRE        = fb_r;
endmodule

//--- pm_mux_assertions.sv
// Concurrent checks on the port 5/6 pin mux, bound to its ports
module pm_mux_assertions
   import pm_pkg::*;
(
   // Clock, reset and serial controls
   input wire logic CLK, RESETN, CHAN_B_I2C_MODE, CHAN_A_CLOCK_NEEDED, CHAN_A_4WIRE_REQ,
   input wire logic CHAN_B_4WIRE_REQ, CHAN_A_FORCE_3WIRE, CHAN_B_FORCE_3WIRE,
   // Port 5 software bits and pads
   input wire logic [7:0] PORT5_DIRECTION_BITS, PORT5_FUNCTION_SELECT, PORT5_OUT_BITS,
   input wire logic [7:0] P5_PAD_IN, P5_PAD_OUT, P5_PAD_OE, PORT5_IN_BITS,
   input wire logic [2:0] SYS_CLOCKS,
   // Serial pad requests
   input wire pm_pkg::pm_sig_s CHAN_A_SERIAL_CLOCK, CHAN_B_SLAVE_STROBE, CHAN_B_MASTER_OUT,
   input wire pm_pkg::pm_sig_s CHAN_B_MASTER_IN, CHAN_B_SERIAL_CLOCK, CHAN_A_SLAVE_STROBE
);
   // One domain; $past guards skip the edge that still sees reset values
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_p50_priority: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[0]) |->
      {P5_PAD_OUT[0], P5_PAD_OE[0]} == ($past(CHAN_A_CLOCK_NEEDED) ?
      $past(CHAN_A_SERIAL_CLOCK) : $past(CHAN_B_SLAVE_STROBE))) else $error("P5.0 wrong source");
   a_p51_route: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[1]) &&
      !$past(CHAN_B_I2C_MODE) |-> {P5_PAD_OUT[1], P5_PAD_OE[1]} == $past(CHAN_B_MASTER_OUT))
      else $error("P5.1 not on master out");
   a_p52_route: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[2]) &&
      !$past(CHAN_B_I2C_MODE) |-> {P5_PAD_OUT[2], P5_PAD_OE[2]} == $past(CHAN_B_MASTER_IN))
      else $error("P5.2 not on master in");
   a_p53_route: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[3]) |->
      {P5_PAD_OUT[3], P5_PAD_OE[3]} == (($past(CHAN_A_4WIRE_REQ) && !$past(CHAN_A_CLOCK_NEEDED))
      ? $past(CHAN_A_SLAVE_STROBE) : $past(CHAN_B_SERIAL_CLOCK))) else $error("P5.3 wrong");
   a_i2c_drive_low: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[1]) &&
      $past(CHAN_B_I2C_MODE) |-> !P5_PAD_OUT[1] && P5_PAD_OE[1] ==
      ($past(CHAN_B_MASTER_OUT.oe) && !$past(CHAN_B_MASTER_OUT.out))) else $error("I2C drove high");
   a_force_a_3wire: assert property ($past(RESETN) |-> CHAN_A_FORCE_3WIRE ==
      $past(PORT5_FUNCTION_SELECT[0] && CHAN_A_CLOCK_NEEDED && CHAN_A_4WIRE_REQ))
      else $error("A 3-wire force wrong");
   a_force_b_3wire: assert property ($past(RESETN) |-> CHAN_B_FORCE_3WIRE ==
      $past(PORT5_FUNCTION_SELECT[0] && CHAN_A_CLOCK_NEEDED && CHAN_B_4WIRE_REQ))
      else $error("B 3-wire force wrong");
   a_gpio_default: assert property ($past(RESETN) |-> (((P5_PAD_OE ^ $past(PORT5_DIRECTION_BITS))
      | (P5_PAD_OUT ^ $past(PORT5_OUT_BITS))) & ~$past(PORT5_FUNCTION_SELECT)) == 8'h00)
      else $error("GPIO pin wrong");
   a_clock_out: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[4]) &&
      $past(PORT5_DIRECTION_BITS[4]) |-> P5_PAD_OUT[4] == $past(SYS_CLOCKS[0]))
      else $error("P5.4 clock wrong");
   a_i2c_clock_low: assert property ($past(RESETN) && $past(PORT5_FUNCTION_SELECT[2]) &&
      $past(CHAN_B_I2C_MODE) |-> !P5_PAD_OUT[2] && P5_PAD_OE[2] ==
      ($past(CHAN_B_MASTER_IN.oe) && !$past(CHAN_B_MASTER_IN.out))) else $error("I2C clock high");
   // All three edges, two synchroniser flops and the readback flop, must be out of reset, or the cleared flops show zeros
   a_pad_readback: assert property ($past(RESETN, 3) && $past(RESETN, 2) && $past(RESETN) |->
      PORT5_IN_BITS == $past(P5_PAD_IN, 3)) else $error("P5 readback wrong");
endmodule
bind pm_mux pm_mux_assertions pm_mux_assertions_i (
   .CLK                   (CLK),
   .RESETN                (RESETN),
   .CHAN_B_I2C_MODE       (CHAN_B_I2C_MODE),
   .CHAN_A_CLOCK_NEEDED   (CHAN_A_CLOCK_NEEDED),
   .CHAN_A_4WIRE_REQ      (CHAN_A_4WIRE_REQ),
   .CHAN_B_4WIRE_REQ      (CHAN_B_4WIRE_REQ),
   .CHAN_A_FORCE_3WIRE    (CHAN_A_FORCE_3WIRE),
   .CHAN_B_FORCE_3WIRE    (CHAN_B_FORCE_3WIRE),
   .PORT5_DIRECTION_BITS  (PORT5_DIRECTION_BITS),
   .PORT5_FUNCTION_SELECT (PORT5_FUNCTION_SELECT),
   .PORT5_OUT_BITS        (PORT5_OUT_BITS),
   .P5_PAD_IN             (P5_PAD_IN),
   .P5_PAD_OUT            (P5_PAD_OUT),
   .P5_PAD_OE             (P5_PAD_OE),
   .PORT5_IN_BITS         (PORT5_IN_BITS),
   .SYS_CLOCKS            (SYS_CLOCKS),
   .CHAN_A_SERIAL_CLOCK   (CHAN_A_SERIAL_CLOCK),
   .CHAN_B_SLAVE_STROBE   (CHAN_B_SLAVE_STROBE),
   .CHAN_B_MASTER_OUT     (CHAN_B_MASTER_OUT),
   .CHAN_B_MASTER_IN      (CHAN_B_MASTER_IN),
   .CHAN_B_SERIAL_CLOCK   (CHAN_B_SERIAL_CLOCK),
   .CHAN_A_SLAVE_STROBE   (CHAN_A_SLAVE_STROBE)
);

//--- pm_far_model.sv
// Model of the serial, clock and supervisor modules and of the board at the pads
module pm_far_model
   import pm_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic [7:0] p5_out, p5_oe, p6_out, p6_oe,
   output logic            i2c, need, a4, b4, svo,
   output pm_sig_s         acl, bst, bmo, bmi, bcl, ast,
   output logic [2:0]      sck,
   output logic [7:0]      pin5, pin6
);
   logic [7:0]  ext5 = 8'h06; // Board level of released port 5 lines
   logic [7:0]  ext6 = 8'h00; // Board level of released port 6 lines
   logic [31:0] r;            // Fresh random word
   initial {i2c, need, a4, b4, svo, sck, acl, bst, bmo, bmi, bcl, ast} = 20'h00000;
   // Peripherals change just after the falling edge, like the bench
   always @(negedge CLK) begin
      r = $urandom;
      {i2c, need, a4, b4, svo, sck} <= r[7:0];
      {acl, bst, bmo, bmi, bcl, ast} <= r[19:8];
      // Released lines: pull-ups on the I2C pair, noise elsewhere so no stale value shows
      ext5 <= r[27:20] | 8'h06;
      ext6 <= {r[31:28], r[3:0]};
   end
   assign pin5 = (p5_out & p5_oe) | (ext5 & ~p5_oe);
   assign pin6 = (p6_out & p6_oe) | (ext6 & ~p6_oe);
endmodule

//--- pm_mux_tb.sv
// Self-checking testbench for the port 5/6 pin mux
module pm_mux_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pm_pkg::*;
   logic       CLK = 1'b0, RESETN = 1'b0;
   logic [7:0] d5 = 8'h00, s5 = 8'h00, o5 = 8'h00, d6 = 8'h00, s6 = 8'h00, o6 = 8'h00;
   logic [7:0] ae = 8'h00, p5o, p5e, p6o, p6e, pin5, pin6, ar, in5, in6, per;
   logic [15:0] h5 = 16'h0000, h6 = 16'h0000; // Pads seen one and two edges back
   logic [3:0] lvl = 4'h0;
   logic [2:0] sck;
   logic       i2c, need, a4, b4, svo, sei, f3a, f3b, thz;
   pm_sig_s    acl, bst, bmo, bmi, bcl, ast;
   logic [71:0] notes[$], n;
   int         fail_count = 0, num_checks = 0;
   always #50 CLK = ~CLK;
   pm_far_model pm_far_model_i (.CLK(CLK), .p5_out(p5o), .p5_oe(p5e), .p6_out(p6o), .p6_oe(p6e),
      .i2c(i2c), .need(need), .a4(a4), .b4(b4), .svo(svo), .acl(acl), .bst(bst), .bmo(bmo),
      .bmi(bmi), .bcl(bcl), .ast(ast), .sck(sck), .pin5(pin5), .pin6(pin6));
   pm_mux pm_mux_i (.CLK(CLK), .RESETN(RESETN), .PORT5_DIRECTION_BITS(d5),
      .PORT5_FUNCTION_SELECT(s5), .PORT5_OUT_BITS(o5), .PORT6_DIRECTION_BITS(d6),
      .PORT6_FUNCTION_SELECT(s6), .PORT6_OUT_BITS(o6), .ANALOG_INPUT_ENABLE(ae),
      .CHAN_B_I2C_MODE(i2c), .CHAN_A_CLOCK_NEEDED(need), .CHAN_A_SERIAL_CLOCK(acl),
      .CHAN_B_SLAVE_STROBE(bst), .CHAN_B_MASTER_OUT(bmo), .CHAN_B_MASTER_IN(bmi),
      .CHAN_B_SERIAL_CLOCK(bcl), .CHAN_A_SLAVE_STROBE(ast), .CHAN_A_4WIRE_REQ(a4),
      .CHAN_B_4WIRE_REQ(b4), .SYS_CLOCKS(sck), .SUPERVISOR_OUTPUT(svo),
      .SUPERVISOR_LEVEL_SELECT(lvl), .P5_PAD_IN(pin5), .P6_PAD_IN(pin6), .P5_PAD_OUT(p5o),
      .P5_PAD_OE(p5e), .P6_PAD_OUT(p6o), .P6_PAD_OE(p6e), .PORT5_IN_BITS(in5),
      .PORT6_IN_BITS(in6), .P5_PERIPH_IN(per), .ANALOG_PIN_ROUTE(ar), .TIMER_OUTPUTS_HIGH_Z(thz),
      .SUPERVISOR_EXTERNAL_INPUT(sei), .CHAN_A_FORCE_3WIRE(f3a), .CHAN_B_FORCE_3WIRE(f3b));
   // Pad history as two input flops see it; cleared with reset like those flops
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) {h5, h6} <= 32'h00000000;
      else {h5, h6} <= {h5[7:0], pin5, h6[7:0], pin6};
   end
   task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask
   // One random cycle of software bits; the expected pads are noted for the monitor
   task automatic step();
      logic [7:0]  e5o, e5e;
      logic [31:0] r;
      @(negedge CLK);
      r = $urandom;
      {d5, s5, d6, o6} = r;
      r = $urandom;
      {o5, ae, lvl} = r[19:0];
      s6 = {r[20], 7'h00}; // Only P6.7 has a defined digital function
      #1;
      e5o = o5;
      e5e = d5;
      if (s5[0]) {e5o[0], e5e[0]} = need ? acl : bst;
      if (s5[1]) {e5o[1], e5e[1]} = i2c ? {1'b0, bmo.oe & ~bmo.out} : bmo;
      if (s5[2]) {e5o[2], e5e[2]} = i2c ? {1'b0, bmi.oe & ~bmi.out} : bmi;
      if (s5[3]) {e5o[3], e5e[3]} = (a4 && !need) ? ast : bcl;
      for (int i = 4; i < 7; i++) if (s5[i]) e5o[i] = sck[i-4];
      if (s5[7]) e5o[7] = svo;
      // Readback shows pads from two edges before the coming one
      notes.push_back({h5[15:8], h6[15:8] & ~ae, h5[15:8] & s5, e5o & e5e, e5e,
         o6 & ~s6 & d6 & ~ae, d6 & ~ae, ae, 4'h0, s5[7] & ~d5[7] & h5[15],
         s5[0] & need & a4, s5[0] & need & b4, ae[7] && (lvl == PM_SVS_EXT_LVL)});
   endtask
   task automatic sweep(string name, int cycles);
      repeat (cycles) step();
      repeat (2) @(posedge CLK);
      #2 $display("TB: test %s done", name);
   endtask
   // Monitor: each registered result is matched with the oldest note
   always @(posedge CLK) begin
      #1;
      if (notes.size() > 0) begin
         n = notes.pop_front();
         check("p5 out", p5o & p5e, n[47:40]);
         check("p5 oe", p5e, n[39:32]);
         check("p6 pads", {p6o & p6e, p6e, ar}, n[31:8]);
         check("flags", {f3a, f3b, sei}, n[2:0]);
         check("readback", {in5, in6, per}, n[71:48]);
         check("timer hi-z", thz, n[3]);
      end
   end
   task automatic finish_test();
      $display("TB: %0d checks, %0d mismatches", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(99624));
      repeat (20) @(posedge CLK);
      @(negedge CLK) RESETN = 1'b1;
      sweep("random sweep", 400);
      @(negedge CLK) RESETN = 1'b0;
      #1 check("outputs in reset", {p5o, p5e, p6o, p6e, ar, in5}, 48'h0);
      check("flags in reset", {in6, per, thz, sei, f3a, f3b}, 48'h0);
      @(negedge CLK) RESETN = 1'b1;
      sweep("after second reset", 300);
      finish_test();
   end
endmodule
